/* output_divider_phase_stepper.sv */
// Purpose: phase stepping of output dividers one to four over AXI4-Lite
// Assumes: aclk is the device clock, 10 MHz, one tick per vco period
// Notes:   registers are one word each; data sits in the low bits
// Function
// - each divider holds 8-bit step size
// - count low byte at step address plus one
// - count high byte at step address plus two
// - writing bit 0 shifts phase later
// - writing bit 1 shifts phase earlier
// - divider two channel starts at 0x0A40
// - four-register stride from 0x0A3C to 0x0A48
// - shift equals step times count vco periods
// - command bits self-clear when sequence ends
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
module output_divider_phase_stepper
#(
  parameter int ADDR_W = 16,
  parameter int OFS_W  = phase_stepper_pkg::OFS_W
)
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // write address channel
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // write data channel
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // write response channel
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // read address channel
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // read data channel
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // phase steps toward the dividers, one tick per vco period
  output logic [3:0]             shift_tick,
  output logic [3:0]             shift_earlier
);

  localparam int N = phase_stepper_pkg::NUM_DIV;

  // register file
  logic [7:0]  step_q  [N];
  logic [15:0] count_q [N];
  logic [1:0]  cmd_q   [N];
  logic [OFS_W-1:0] offset [N];
  logic [N-1:0] start_q;
  logic [N-1:0] done;
  logic [N-1:0] busy;
  logic [N-1:0] tick;
  logic [N-1:0] tick_earlier;

  // bus state
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic              aw_have_d;
  logic              w_have_d;
  logic              bvalid_d;
  logic              rvalid_d;
  logic              do_write;
  logic              ar_take;
  phase_stepper_pkg::reg_sel_t wsel;
  phase_stepper_pkg::reg_sel_t rsel;

  // word decode shared by read and write paths
  function automatic phase_stepper_pkg::reg_sel_t decode
  (
    input logic [ADDR_W-1:0] addr
  );
    phase_stepper_pkg::reg_sel_t sel;
    logic [13:0] idx;
    sel.field = phase_stepper_pkg::FIELD_NONE;
    sel.chan  = 2'h0;
    idx = addr[15:2];
    // low two bits must be zero for an aligned word
    for (int i = 0; i < N; i++)
    begin
      if (addr[1:0] == 2'h0)
      begin
        if (idx == phase_stepper_pkg::STEP_IDX[i])
        begin
          sel.field = phase_stepper_pkg::FIELD_STEP;
          sel.chan  = 2'(i);
        end
        if (idx == phase_stepper_pkg::CNT_LO_IDX[i])
        begin
          sel.field = phase_stepper_pkg::FIELD_CNT_LO;
          sel.chan  = 2'(i);
        end
        if (idx == phase_stepper_pkg::CNT_HI_IDX[i])
        begin
          sel.field = phase_stepper_pkg::FIELD_CNT_HI;
          sel.chan  = 2'(i);
        end
        if (idx == phase_stepper_pkg::CMD_IDX[i])
        begin
          sel.field = phase_stepper_pkg::FIELD_CMD;
          sel.chan  = 2'(i);
        end
        if (idx == phase_stepper_pkg::OFFSET_IDX[i])
        begin
          sel.field = phase_stepper_pkg::FIELD_OFFSET;
          sel.chan  = 2'(i);
        end
      end
    end
    return sel;
  endfunction

  // write channel handshake: address and data taken in either order
  always_comb
  begin
    do_write  = aw_have_q && w_have_q && !s_axi_bvalid;
    aw_have_d = (aw_have_q && !do_write) || (s_axi_awvalid && s_axi_awready);
    w_have_d  = (w_have_q && !do_write) || (s_axi_wvalid && s_axi_wready);
    bvalid_d  = do_write || (s_axi_bvalid && !s_axi_bready);
    ar_take   = s_axi_arvalid && s_axi_arready;
    rvalid_d  = ar_take || (s_axi_rvalid && !s_axi_rready);
    wsel      = decode(aw_addr_q);
    rsel      = decode(s_axi_araddr);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
    end
    else
    begin
      aw_have_q     <= aw_have_d;
      w_have_q      <= w_have_d;
      // hold off new requests until the response is taken
      s_axi_awready <= !aw_have_d && !bvalid_d;
      s_axi_wready  <= !w_have_d && !bvalid_d;
      if (s_axi_awvalid && s_axi_awready)
        aw_addr_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= phase_stepper_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_bvalid <= bvalid_d;
      if (do_write)
        s_axi_bresp <= (wsel.field == phase_stepper_pkg::FIELD_NONE) ?
                       phase_stepper_pkg::RESP_SLVERR :
                       phase_stepper_pkg::RESP_OKAY;
    end
  end

  // step and count registers; only byte lane 0 carries data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < N; i++)
      begin
        step_q[i]  <= phase_stepper_pkg::STEP_RESET;
        count_q[i] <= phase_stepper_pkg::COUNT_RESET;
      end
    end
    else if (do_write && w_strb_q[0])
    begin
      case (wsel.field)
        phase_stepper_pkg::FIELD_STEP:
          step_q[wsel.chan] <= w_data_q[7:0];
        phase_stepper_pkg::FIELD_CNT_LO:
          count_q[wsel.chan][7:0] <= w_data_q[7:0];
        phase_stepper_pkg::FIELD_CNT_HI:
          count_q[wsel.chan][15:8] <= w_data_q[7:0];
        default:
        begin
        end
      endcase
    end
  end

  // command bits: set by a legal write, cleared when the sequence ends
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < N; i++)
        cmd_q[i] <= phase_stepper_pkg::CMD_RESET;
      start_q <= '0;
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        start_q[i] <= 1'b0;
        if (done[i])
          cmd_q[i] <= phase_stepper_pkg::CMD_RESET;
        // a running channel never sees done and start together
        else if (do_write && w_strb_q[0] && cmd_q[i] == 2'h0 &&
                 !busy[i] &&
                 wsel.field == phase_stepper_pkg::FIELD_CMD &&
                 wsel.chan == 2'(i) &&
                 (w_data_q[phase_stepper_pkg::CMD_LATER_BIT] ^
                  w_data_q[phase_stepper_pkg::CMD_EARLIER_BIT]))
        begin
          cmd_q[i]   <= w_data_q[1:0];
          start_q[i] <= 1'b1;
        end
      end
    end
  end

  // read path: one read at a time, data a cycle after the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= phase_stepper_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (ar_take)
      begin
        s_axi_rresp <= phase_stepper_pkg::RESP_OKAY;
        case (rsel.field)
          phase_stepper_pkg::FIELD_STEP:
            s_axi_rdata <= {24'h000000, step_q[rsel.chan]};
          phase_stepper_pkg::FIELD_CNT_LO:
            s_axi_rdata <= {24'h000000, count_q[rsel.chan][7:0]};
          phase_stepper_pkg::FIELD_CNT_HI:
            s_axi_rdata <= {24'h000000, count_q[rsel.chan][15:8]};
          phase_stepper_pkg::FIELD_CMD:
            s_axi_rdata <= {30'h0, cmd_q[rsel.chan]};
          phase_stepper_pkg::FIELD_OFFSET:
            s_axi_rdata <= {{(32-OFS_W){offset[rsel.chan][OFS_W-1]}},
                            offset[rsel.chan]};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= phase_stepper_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // tick outputs retimed so the pins come straight from flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shift_tick    <= 4'h0;
      shift_earlier <= 4'h0;
    end
    else
    begin
      shift_tick    <= tick;
      shift_earlier <= tick_earlier;
    end
  end

  // one sequencer and tracker per divider
  for (genvar g = 0; g < N; g++)
  begin : g_div
    step_link_if link ();

    assign link.start   = start_q[g];
    assign link.earlier = cmd_q[g][phase_stepper_pkg::CMD_EARLIER_BIT];
    assign link.step    = step_q[g];
    assign link.count   = count_q[g];
    assign done[g]         = link.done;
    assign busy[g]         = link.busy;
    assign tick[g]         = link.tick;
    assign tick_earlier[g] = link.tick_earlier;

    phase_step_channel u_chan
    (
      .aclk    (aclk),
      .aresetn (aresetn),
      .link    (link)
    );

    phase_offset_tracker #(.OFS_W(OFS_W)) u_track
    (
      .aclk    (aclk),
      .aresetn (aresetn),
      .link    (link),
      .offset  (offset[g])
    );
  end

endmodule

/* phase_stepper_pkg.sv */
// Purpose: shared constants and types for the output divider phase stepper
// Assumes: register indices are word indices; byte address is index * 4
// Notes:   channel 0 in arrays is divider one, channel 3 is divider four
package phase_stepper_pkg;

  localparam int NUM_DIV  = 4;
  localparam int IDX_W    = 14;
  localparam int STEP_W   = 8;
  localparam int COUNT_W  = 16;
  localparam int OFS_W    = 24;

  // register indices, one word each on the bus
  localparam logic [13:0] STEP_IDX [4] =
    '{14'h0a3c, 14'h0a40, 14'h0a44, 14'h0a48};
  localparam logic [13:0] CNT_LO_IDX [4] =
    '{14'h0a3d, 14'h0a41, 14'h0a45, 14'h0a49};
  localparam logic [13:0] CNT_HI_IDX [4] =
    '{14'h0a3e, 14'h0a42, 14'h0a46, 14'h0a4a};
  localparam logic [13:0] CMD_IDX [4] =
    '{14'h0a3f, 14'h0a43, 14'h0a47, 14'h0a4b};
  // read-only accumulated phase offset per divider
  localparam logic [13:0] OFFSET_IDX [4] =
    '{14'h0a4c, 14'h0a4d, 14'h0a4e, 14'h0a4f};

  // command field positions
  localparam int CMD_LATER_BIT   = 0;
  localparam int CMD_EARLIER_BIT = 1;

  // values after reset
  localparam logic [7:0]  STEP_RESET  = 8'h01;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0]  CMD_RESET   = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0]
  {
    FIELD_NONE,
    FIELD_STEP,
    FIELD_CNT_LO,
    FIELD_CNT_HI,
    FIELD_CMD,
    FIELD_OFFSET
  } field_t;

  typedef struct packed
  {
    field_t     field;
    logic [1:0] chan;
  } reg_sel_t;

endpackage

/* step_link_if.sv */
// Purpose: link between register file, sequencer and offset tracker
// Assumes: one instance per divider channel
// Notes:   start is a one-cycle pulse; done is a one-cycle pulse
`timescale 1ns/1ns
interface step_link_if;
  logic        start;
  logic        earlier;
  logic [7:0]  step;
  logic [15:0] count;
  logic        busy;
  logic        done;
  logic        tick;
  logic        tick_earlier;

  modport ctrl
  (
    output start, earlier, step, count,
    input  busy, done, tick, tick_earlier
  );
  modport chan
  (
    input  start, earlier, step, count,
    output busy, done, tick, tick_earlier
  );
  modport track
  (
    input tick, tick_earlier
  );
endinterface

/* phase_step_channel.sv */
// Purpose: sequencer emitting one tick per vco period of phase shift
// Assumes: aclk stands for the vco-derived clock, one period per tick
// Notes:   step and count are latched at start; later writes do not disturb
`timescale 1ns/1ns
module phase_step_channel
(
  // clock and reset
  input  wire logic  aclk,
  input  wire logic  aresetn,
  // link to register file
  step_link_if.chan  link
);

  typedef enum logic {ST_IDLE, ST_RUN} seq_state_t;

  seq_state_t  state_q;
  logic [7:0]  step_q;
  logic [7:0]  step_left_q;
  logic [15:0] count_left_q;
  logic        tick_q;
  logic        earlier_q;
  logic        done_q;

  assign link.busy         = (state_q == ST_RUN);
  assign link.done         = done_q;
  assign link.tick         = tick_q;
  assign link.tick_earlier = earlier_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q      <= ST_IDLE;
      step_q       <= 8'h00;
      step_left_q  <= 8'h00;
      count_left_q <= 16'h0000;
      tick_q       <= 1'b0;
      earlier_q    <= 1'b0;
      done_q       <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          tick_q <= 1'b0;
          done_q <= 1'b0;
          if (link.start)
          begin
            earlier_q    <= link.earlier;
            step_q       <= link.step;
            step_left_q  <= link.step;
            count_left_q <= link.count;
            // zero step or zero count means no shift; finish at once
            if (link.step == 8'h00 || link.count == 16'h0000)
              done_q <= 1'b1;
            else
              state_q <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          tick_q <= 1'b1;
          if (step_left_q == 8'h01)
          begin
            if (count_left_q == 16'h0001)
            begin
              state_q <= ST_IDLE;
              done_q  <= 1'b1;
            end
            else
            begin
              count_left_q <= count_left_q - 16'h0001;
              step_left_q  <= step_q;
            end
          end
          else
            step_left_q <= step_left_q - 8'h01;
        end
        default:
        begin
          state_q <= ST_IDLE;
          tick_q  <= 1'b0;
          done_q  <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* phase_offset_tracker.sv */
// Purpose: running signed phase offset of one divider in vco periods
// Assumes: later shifts count up, earlier shifts count down
// Notes:   wraps silently at the counter width
`timescale 1ns/1ns
module phase_offset_tracker
#(
  parameter int OFS_W = 24
)
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // tick stream from the sequencer
  step_link_if.track             link,
  // accumulated offset
  output logic signed [OFS_W-1:0] offset
);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      offset <= '0;
    else if (link.tick && link.tick_earlier)
      offset <= offset - OFS_W'(1);
    else if (link.tick)
      offset <= offset + OFS_W'(1);
  end

endmodule

/* output_divider_phase_stepper_asserts.sv */
// Purpose: bus handshake and tick stream checks for the phase stepper
// Assumes: aclk rising edge, aresetn synchronous active low
// Notes:   sees only top-level ports, bound after the module
`timescale 1ns/1ns
module output_divider_phase_stepper_asserts
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // tick stream
  input wire logic [3:0]  shift_tick,
  input wire logic [3:0]  shift_earlier
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  write_resp_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write response");
  write_busy_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
  write_ready_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
      ##[0:1] s_axi_awready) else $error("write path not reopened");
  read_resp_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read data after address");
  read_busy_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
  read_done_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data not withdrawn");
  err_data_a:
    assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 0)
      else $error("error read carries data");
  tick_dir_a:
    assert property ((shift_tick & $past(shift_tick) &
      (shift_earlier ^ $past(shift_earlier))) == 4'h0)
      else $error("direction changed inside a run");
endmodule

bind output_divider_phase_stepper output_divider_phase_stepper_asserts u_chk
(
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .shift_tick(shift_tick),
  .shift_earlier(shift_earlier)
);

/* tb_top.sv */
// Purpose: self-checking bench for the output divider phase stepper
// Assumes: one AXI4-Lite write and one read at a time
// Notes:   tick totals are counted by a monitor on the tick outputs
`timescale 1ns/1ns
module tb_top;
  logic        aclk;
  logic        aresetn;
  logic [15:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [15:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [3:0]  shift_tick;
  logic [3:0]  shift_earlier;
  int          n_fail;
  int          compares;
  int          ticks [4];
  int          early [4];
  int          exp_ofs [4];

  output_divider_phase_stepper dut
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .shift_tick(shift_tick), .shift_earlier(shift_earlier)
  );

  always #50 aclk = ~aclk;

  always @(posedge aclk)
    for (int i = 0; i < 4; i++)
      if (shift_tick[i] === 1'b1)
      begin
        ticks[i]++;
        if (shift_earlier[i] === 1'b1)
          early[i]++;
      end

  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // byte address of register k of divider i, worked out independently
  function automatic logic [15:0] rb(input int i, input int k);
    return 16'((32'h0a3c + i * 4 + k) * 4);
  endfunction

  task axi_write(input logic [15:0] a, input logic [31:0] d,
                 output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task axi_read(input logic [15:0] a, output logic [31:0] d,
                output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check(32'(r), 32'h0);
  endtask

  task rd(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(d, e);
    check(32'(r), 32'h0);
  endtask

  task reset_values;
    for (int i = 0; i < 4; i++)
    begin
      rd(rb(i, 0), 32'h01);
      rd(rb(i, 1), 32'h0);
      rd(rb(i, 2), 32'h0);
      rd(rb(i, 3), 32'h0);
      rd(16'(phase_stepper_pkg::OFFSET_IDX[i] * 4), 32'h0);
    end
  endtask

  // reset in mid-run must drop the sequence, command and offset
  task reset_mid_run;
    int t0;
    wr(rb(1, 0), 32'h10);
    wr(rb(1, 1), 32'h08);
    wr(rb(1, 2), 32'h00);
    wr(rb(1, 3), 32'h1);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t0 = ticks[1];
    rd(rb(1, 3), 32'h0);
    rd(rb(1, 0), 32'h01);
    rd(16'(phase_stepper_pkg::OFFSET_IDX[1] * 4), 32'h0);
    check(ticks[1] - t0, 32'h0);
  endtask

  // upper bits written must not land in the 8-bit fields
  task reg_rw;
    for (int i = 0; i < 4; i++)
    begin
      wr(rb(i, 0), 32'h1c0 + i);
      wr(rb(i, 1), 32'h350 + i);
      wr(rb(i, 2), 32'h7a0 + i);
    end
    for (int i = 0; i < 4; i++)
    begin
      rd(rb(i, 0), 32'hc0 + i);
      rd(rb(i, 1), 32'h50 + i);
      rd(rb(i, 2), 32'ha0 + i);
    end
  endtask

  task unmapped;
    logic [31:0] d;
    logic [1:0] r;
    axi_read(16'h2940, d, r);
    check(32'(r), 32'h2);
    check(d, 32'h0);
    axi_write(16'h2940, 32'h5, r);
    check(32'(r), 32'h2);
    axi_write(rb(0, 0) + 16'h1, 32'h77, r);
    check(32'(r), 32'h2);
    rd(rb(0, 0), 32'hc0);
  endtask

  // extra is a second command written while the first is running
  task run(input int ch, input logic [7:0] st, input logic [15:0] cn,
           input logic [1:0] cmd, input logic [1:0] extra);
    int t0;
    int e0;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    n = (cmd == 2'h3) ? 0 : st * cn;
    wr(rb(ch, 0), 32'(st));
    wr(rb(ch, 1), 32'(cn[7:0]));
    wr(rb(ch, 2), 32'(cn[15:8]));
    t0 = ticks[ch];
    e0 = early[ch];
    wr(rb(ch, 3), 32'(cmd));
    if (extra != 2'h0)
      wr(rb(ch, 3), 32'(extra));
    rd(rb(ch, 3), (cmd == 2'h3) ? 32'h0 : 32'(cmd));
    do axi_read(rb(ch, 3), d, r); while (d !== 32'h0);
    repeat (3) @(posedge aclk);
    check(ticks[ch] - t0, n);
    check(early[ch] - e0, (cmd == 2'h2) ? n : 0);
    exp_ofs[ch] += (cmd == 2'h1) ? n : (cmd == 2'h2) ? -n : 0;
    rd(16'(phase_stepper_pkg::OFFSET_IDX[ch] * 4), exp_ofs[ch]);
  endtask

  task print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    print_verdict;
  end

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    s_axi_awaddr = 16'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 16'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    reset_values;
    reg_rw;
    unmapped;
    run(0, 8'h02, 16'h000b, 2'h1, 2'h0);
    run(1, 8'h03, 16'h0101, 2'h2, 2'h0);
    run(2, 8'h04, 16'h0005, 2'h1, 2'h2);
    run(3, 8'hff, 16'h0001, 2'h3, 2'h0);
    run(3, 8'hff, 16'h0001, 2'h2, 2'h0);
    run(0, 8'h01, 16'h0014, 2'h2, 2'h0);
    reset_mid_run;
    print_verdict;
  end
endmodule
